// File: hw/ppr_defines.vh
// Purpose: Shared constants for the PHY reset, clocking and power-state block
// Assumes: pclk at 125 MHz; APB register window of 4 KiB
// Notes:   Every offset, control and status field position, control reset value and timing count lives here
//
// Notes on behaviour
// [RL1] Encode each accepted byte with 8b/10b
// [RL2] Shift each ten-bit symbol out serially
// [RL3] Parallel and bit clocks come from reference
// [RL4] Capture tx inputs on tx source clock rise
// [RL5] MAC keeps tx clock equal to rx clock; the MAC model runs 80 ns, not the 32 ns run-rate rx clock
// [RL6] Drive rx clock, launch status against it
// [RL7] MAC holds reset until power, reference stable
// [RL8] Clocks stable within 64 us after reset
// [RL9] Rx clock runs at reference rate meanwhile
// [RL10] Done flag high until clocks stable, then low
// [RL11] MAC keeps safe control levels during reset
// [RL12] MAC may reset on reset packet
// [RL13] Four power states; link only in full power
// [RL14] Power saving starts at once leaving full
// [RL15] Clocks run; one-cycle done pulse per transition
// [RL16] MAC waits for done before next request
// [RL17] MAC holds idle request in standby, low
// [RL18] MAC requests standby only with tx idle
// [RL19] Standby: tx, rx idle; PLLs, rx clock on
// [RL20] Rx idle saves power; fast relock if locked
// [RL21] MAC requests low power with both idle
// [RL22] Low power: recovery off, tx PLL on, pulse
// [RL23] Deep sleep request acts as low power
// [RL24] One done flag reports several completions
// [RL25] Two-bit request; a change starts handshake
`ifndef PPR_DEFINES_VH
`define PPR_DEFINES_VH

// Timing
`define PPR_PCLK_MHZ         14'h007D
`define PPR_STAB_TIME_US     14'h0040
`define PPR_STAB_CYCLES      (`PPR_STAB_TIME_US * `PPR_PCLK_MHZ)
`define PPR_REF_LOCK_EDGES   5'h10
`define PPR_RX_SOURCE_CLK_HALF_REF   3'h5
`define PPR_RX_SOURCE_CLK_HALF_RUN   3'h2

// Power state request codes
`define PPR_PWR_FULL         2'h0
`define PPR_PWR_STANDBY      2'h1
`define PPR_PWR_LOW          2'h2
`define PPR_PWR_DEEP         2'h3

// Synchroniser vector layout
`define PPR_SYNC_W           16
`define PPR_SYN_TX_SOURCE_CLK        0
`define PPR_SYN_BYTE_LO      1
`define PPR_SYN_BYTE_HI      8
`define PPR_SYN_K            9
`define PPR_SYN_PWR_LO       10
`define PPR_SYN_PWR_HI       11
`define PPR_SYN_IDLE         12
`define PPR_SYN_COMP         13
`define PPR_SYN_REF          14
`define PPR_SYN_RXIDLE       15

// APB register map
`define PPR_ADDR_CTRL        12'h000
`define PPR_ADDR_STATUS      12'h004
`define PPR_ADDR_SYMCNT      12'h008
`define PPR_CTRL_FORCE_IDLE  0
`define PPR_CTRL_RESET       1'h0
`define PPR_ST_STABLE        0
`define PPR_ST_PWR_LO        1
`define PPR_ST_PWR_HI        2
`define PPR_ST_REF_LOCK      3
`define PPR_ST_PENDING       4

// Symbol layout
`define PPR_SYM_LAST_BIT     4'h9
`define PPR_K28_X            5'h1C
`define PPR_K28_6B           6'h0F
`define PPR_ALT7_4B          4'h7

`endif

// File: hw/ppr_enc8b10b.v
// Purpose: 8b/10b encoder with running disparity, one symbol per load
// Assumes: load is a one-cycle strobe on pclk
// Notes:   Symbol bit 9 is line bit a, the first bit on the wire
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_enc8b10b (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       load,
  input  wire [7:0] data,
  input  wire       is_k,
  input  wire       force_neg,
  output reg  [9:0] symbol,
  output reg        sym_valid
);
  reg       rd_reg;
  reg       rd_in, rd_mid, unbal6, unbal4, k28, alt7, inv6, inv4;
  reg [5:0] c6;
  reg [3:0] c4;
  wire [4:0] x = data[4:0];
  wire [2:0] y = data[7:5];

  // Negative-disparity 5b/6b table, abcdei
  function [5:0] code6;
    input [4:0] v;
    case (v)
      5'h00: code6 = 6'h27; 5'h01: code6 = 6'h1D; 5'h02: code6 = 6'h2D; 5'h03: code6 = 6'h31;
      5'h04: code6 = 6'h35; 5'h05: code6 = 6'h29; 5'h06: code6 = 6'h19; 5'h07: code6 = 6'h38;
      5'h08: code6 = 6'h39; 5'h09: code6 = 6'h25; 5'h0A: code6 = 6'h15; 5'h0B: code6 = 6'h34;
      5'h0C: code6 = 6'h0D; 5'h0D: code6 = 6'h2C; 5'h0E: code6 = 6'h1C; 5'h0F: code6 = 6'h17;
      5'h10: code6 = 6'h1B; 5'h11: code6 = 6'h23; 5'h12: code6 = 6'h13; 5'h13: code6 = 6'h32;
      5'h14: code6 = 6'h0B; 5'h15: code6 = 6'h2A; 5'h16: code6 = 6'h1A; 5'h17: code6 = 6'h3A;
      5'h18: code6 = 6'h33; 5'h19: code6 = 6'h26; 5'h1A: code6 = 6'h16; 5'h1B: code6 = 6'h36;
      5'h1C: code6 = 6'h0E; 5'h1D: code6 = 6'h2E; 5'h1E: code6 = 6'h1E; default: code6 = 6'h2B;
    endcase
  endfunction

  // Negative-disparity 3b/4b table, fghj
  function [3:0] code4;
    input [2:0] v;
    case (v)
      3'h0: code4 = 4'hB; 3'h1: code4 = 4'h9; 3'h2: code4 = 4'h5; 3'h3: code4 = 4'hC;
      3'h4: code4 = 4'hD; 3'h5: code4 = 4'hA; 3'h6: code4 = 4'h6; default: code4 = 4'hE;
    endcase
  endfunction

  // Disparity-aware selection of both sub-blocks
  always @* begin
    rd_in  = force_neg ? 1'b0 : rd_reg;            // Compliance forces negative start
    k28    = is_k && (x == `PPR_K28_X);
    c6     = k28 ? `PPR_K28_6B : code6(x);
    unbal6 = ((c6[0] + c6[1] + c6[2] + c6[3] + c6[4] + c6[5]) != 3'h3);
    inv6   = rd_in & (unbal6 | (x == 5'h07));
    rd_mid = rd_in ^ unbal6;
    alt7   = (y == 3'h7) & (is_k | (~rd_mid & ((x == 5'h11) | (x == 5'h12) | (x == 5'h14)))
                               | (rd_mid & ((x == 5'h0B) | (x == 5'h0D) | (x == 5'h0E))));
    c4     = alt7 ? `PPR_ALT7_4B : code4(y);
    unbal4 = ((c4[0] + c4[1] + c4[2] + c4[3]) != 3'h2);
    // K28 flips its balanced trailers against the data form
    if (k28 && !unbal4 && (y != 3'h3))
      inv4 = ~rd_mid;
    else
      inv4 = rd_mid & (unbal4 | (y == 3'h3));
  end

  // Register the symbol and the running disparity
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg    <= 1'b0;
      symbol    <= 10'h000;
      sym_valid <= 1'b0;
    end else begin
      sym_valid <= load;
      if (load) begin
        symbol <= {(inv6 ? ~c6 : c6), (inv4 ? ~c4 : c4)};  // [RL1]
        rd_reg <= rd_mid ^ unbal4;
      end
    end
  end
endmodule

// File: hw/ppr_serializer.v
// Purpose: Parallel-to-serial converter for ten-bit symbols
// Assumes: at most one symbol offered per ten clocks
// Notes:   One holding slot; a late symbol leaves the line idle between symbols
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_serializer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [9:0] sym_in,
  input  wire       sym_load,
  output reg        ser_bit,
  output reg        ser_idle,
  output reg        sym_sent
);
  reg [9:0] shift_reg;
  reg [9:0] hold_reg;
  reg       hold_full_reg;
  reg       busy_reg;
  reg [3:0] bit_cnt_reg;

  // Shift MSB first; reload from the holding slot on the last bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg     <= 10'h000;
      hold_reg      <= 10'h000;
      hold_full_reg <= 1'b0;
      busy_reg      <= 1'b0;
      bit_cnt_reg   <= 4'h0;
      ser_bit       <= 1'b0;
      ser_idle      <= 1'b1;
      sym_sent      <= 1'b0;
    end else begin
      sym_sent <= 1'b0;
      if (sym_load)
        hold_reg <= sym_in;
      if (!busy_reg || (bit_cnt_reg == `PPR_SYM_LAST_BIT)) begin
        if (hold_full_reg) begin
          shift_reg     <= hold_reg;                     // [RL2]
          ser_bit       <= hold_reg[9];
          ser_idle      <= 1'b0;
          busy_reg      <= 1'b1;
          bit_cnt_reg   <= 4'h0;
          sym_sent      <= 1'b1;
          hold_full_reg <= sym_load;
        end else begin
          busy_reg      <= 1'b0;
          ser_idle      <= 1'b1;
          ser_bit       <= 1'b0;
          hold_full_reg <= sym_load;
        end
      end else begin
        shift_reg   <= {shift_reg[8:0], 1'b0};           // [RL2]
        ser_bit     <= shift_reg[8];
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (sym_load)
          hold_full_reg <= 1'b1;
      end
    end
  end
endmodule

// File: hw/ppr_top.v
// Purpose: Reset stabilisation, clocking and power-state control of a x1 PHY
// Assumes: pclk 125 MHz; tx source clock, reference and pins are asynchronous
// Notes:   Clocks are modelled by pclk dividers; the serial lane runs one bit per pclk
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_top #(
  parameter [13:0] STAB_CYCLES = `PPR_STAB_CYCLES
) (
  // Clock, reset and register bus
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,

  // MAC side and lane inputs
  input  wire        ref_clk_in,
  input  wire        tx_source_clk,
  input  wire [7:0]  tx_byte_bus,
  input  wire        tx_data_k,
  input  wire [1:0]  power_state_req,
  input  wire        tx_elec_idle_req,
  input  wire        tx_compliance_req,
  input  wire        rx_elec_idle_in,

  // Generated clock, status and analog controls
  output reg         rx_source_clk,
  output reg         phy_done_flag,
  output wire        tx_serial_data,
  output wire        tx_serial_idle,
  output reg         tx_drive_enable,
  output reg         tx_pll_enable,
  output reg         rx_cdr_enable,
  output reg         rx_front_power_save,
  output reg         rx_fast_relock_ok
);

  //////////
  // Input synchronisers
  // Clock pins are treated as plain data here
  //////////

  wire [`PPR_SYNC_W-1:0] sync_raw;
  reg  [`PPR_SYNC_W-1:0] sync_meta;
  reg  [`PPR_SYNC_W-1:0] sync_q;

  // Every MAC-side and lane pin and foreign clock crosses here before any logic sees it
  assign sync_raw = {rx_elec_idle_in, ref_clk_in,
                     tx_compliance_req, tx_elec_idle_req,
                     power_state_req, tx_data_k,
                     tx_byte_bus, tx_source_clk};

  // Two flops per bit; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `PPR_SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_meta[gi] <= 1'b0;
          sync_q[gi]    <= 1'b0;
        end else begin
          sync_meta[gi] <= sync_raw[gi];
          sync_q[gi]    <= sync_meta[gi];
        end
      end
    end
  endgenerate

  wire       tx_source_clk_s  = sync_q[`PPR_SYN_TX_SOURCE_CLK];
  wire [7:0] byte_s   = sync_q[`PPR_SYN_BYTE_HI:`PPR_SYN_BYTE_LO];
  wire       k_s      = sync_q[`PPR_SYN_K];
  wire [1:0] pwr_s    = sync_q[`PPR_SYN_PWR_HI:`PPR_SYN_PWR_LO];
  wire       idle_s   = sync_q[`PPR_SYN_IDLE];
  wire       comp_s   = sync_q[`PPR_SYN_COMP];
  wire       ref_s    = sync_q[`PPR_SYN_REF];
  wire       rxidle_s = sync_q[`PPR_SYN_RXIDLE];

  //////////
  // Edge detection on the synchronised clocks
  // Low after reset matches the idle clock level
  //////////

  reg  tx_source_clk_d_reg;
  reg  ref_d_reg;
  wire tx_rise  = tx_source_clk_s & ~tx_source_clk_d_reg;
  wire ref_rise = ref_s & ~ref_d_reg;

  // Data and clock share the same sync delay, so a centred rise samples mid-eye
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_source_clk_d_reg <= 1'b0;
      ref_d_reg   <= 1'b0;
    end else begin
      tx_source_clk_d_reg <= tx_source_clk_s;
      ref_d_reg   <= ref_s;
    end
  end

  //////////
  // Reset stabilisation
  // Timer and reference check run side by side
  // Short timer values are for simulation only
  //////////

  reg [13:0] stab_cnt_reg;
  reg [4:0]  ref_edges_reg;
  reg        clocks_stable_reg;
  wire       ref_locked = (ref_edges_reg == `PPR_REF_LOCK_EDGES);

  // Stable needs the reference seen toggling and the settle count expired;
  // a missing reference keeps the block in stabilisation indefinitely
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_reg      <= 14'h0000;
      ref_edges_reg     <= 5'h00;
      clocks_stable_reg <= 1'b0;
    end else begin
      if (ref_rise && !ref_locked)
        ref_edges_reg <= ref_edges_reg + 5'h01;          // [RL3]
      if (stab_cnt_reg != STAB_CYCLES)
        stab_cnt_reg <= stab_cnt_reg + 14'h0001;
      if ((stab_cnt_reg == STAB_CYCLES) && ref_locked)
        clocks_stable_reg <= 1'b1;                       // [RL8] [RL3]
    end
  end

  //////////
  // Receive source clock generation
  // Slow rate until stable, run rate after
  //////////

  reg  [2:0] rxdiv_cnt_reg;
  wire [2:0] rx_half  = clocks_stable_reg ? `PPR_RX_SOURCE_CLK_HALF_RUN : `PPR_RX_SOURCE_CLK_HALF_REF;
  wire       rx_flip  = (rxdiv_cnt_reg >= (rx_half - 3'h1));
  wire       rx_fall  = rx_flip & rx_source_clk;

  // Rate change takes effect mid half period but never cuts it below the run half period, so no runt pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxdiv_cnt_reg <= 3'h0;
      rx_source_clk <= 1'b0;
    end else if (rx_flip) begin
      rxdiv_cnt_reg <= 3'h0;
      rx_source_clk <= ~rx_source_clk;                   // [RL9] [RL6]
    end else begin
      rxdiv_cnt_reg <= rxdiv_cnt_reg + 3'h1;
    end
  end

  //////////
  // Power state tracking
  // Any changed code seen once clocks are stable is a new transition
  // Deep sleep folds onto low power
  //////////

  reg  [1:0] cur_pwr_reg;
  reg  [1:0] last_req_reg;
  reg        trans_pending_reg;
  wire [1:0] req_mapped = (pwr_s == `PPR_PWR_DEEP) ? `PPR_PWR_LOW : pwr_s;
  wire       req_change = tx_rise & clocks_stable_reg & (pwr_s != last_req_reg);
  wire       is_full    = (cur_pwr_reg == `PPR_PWR_FULL);
  wire       is_standby = (cur_pwr_reg == `PPR_PWR_STANDBY);
  wire       is_low     = (cur_pwr_reg == `PPR_PWR_LOW);
  wire       done_slot  = rx_fall & clocks_stable_reg;

  // Requests are taken on tx clock rises; the state switches at once so
  // power saving starts without waiting for the handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pwr_reg       <= `PPR_PWR_LOW;
      last_req_reg      <= `PPR_PWR_LOW;
      trans_pending_reg <= 1'b0;
    end else begin
      if (tx_rise)
        last_req_reg <= pwr_s;                           // [RL25] [RL4]
      if (req_change) begin
        cur_pwr_reg       <= req_mapped;                 // [RL23] [RL14] [RL13]
        trans_pending_reg <= 1'b1;                       // [RL25]
      end else if (done_slot) begin
        trans_pending_reg <= 1'b0;
      end
    end
  end

  //////////
  // Completion flag, launched on rx clock falling edges
  // A request in a done slot defers the pulse
  // so that transition and the new one share one later pulse
  //////////

  // High through stabilisation, then one rx clock period per transition
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_done_flag <= 1'b1;                             // [RL10]
    end else if (!clocks_stable_reg) begin
      phy_done_flag <= 1'b1;                             // [RL10]
    end else if (done_slot) begin
      phy_done_flag <= trans_pending_reg & ~req_change;  // [RL15] [RL22] [RL24] [RL6]
    end
  end

  //////////
  // Analog block enables
  // All enables stay off until clocks are stable
  //////////

  reg rx_locked_before_reg;

  // Recovery drops in low power; tx PLL and rx clock stay on in every state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_drive_enable      <= 1'b0;
      tx_pll_enable        <= 1'b0;
      rx_cdr_enable        <= 1'b0;
      rx_front_power_save  <= 1'b0;
      rx_fast_relock_ok    <= 1'b0;
      rx_locked_before_reg <= 1'b0;
    end else begin
      tx_pll_enable       <= clocks_stable_reg;                        // [RL15] [RL19]
      tx_drive_enable     <= clocks_stable_reg & is_full;              // [RL13] [RL19]
      rx_cdr_enable       <= clocks_stable_reg & ~is_low;              // [RL22] [RL19]
      rx_front_power_save <= clocks_stable_reg & (is_full | is_standby)
                             & rxidle_s; // [RL20]
      // Lock history survives idle gaps but not a trip through low power
      if (!clocks_stable_reg || is_low)
        rx_locked_before_reg <= 1'b0;
      else if (!rxidle_s)
        rx_locked_before_reg <= 1'b1;
      rx_fast_relock_ok   <= rx_locked_before_reg
                             & (is_full | is_standby); // [RL20]
    end
  end

  //////////
  // APB slave
  // Map:
  //   000 control: bit 0 holds tx data off
  //   004 status: stable, state, lock, pending
  //   008 symbol count, read only
  // Other words answer with an error
  //////////

  reg        force_idle_reg;
  reg [15:0] sym_cnt_reg;
  reg [31:0] rd_mux;
  reg        addr_hit;
  wire       apb_setup = psel & ~penable;
  wire       apb_write = psel & penable & pready & pwrite & ~pslverr;

  // Read mux; unmapped words read zero and answer with an error
  always @* begin
    rd_mux   = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      `PPR_ADDR_CTRL: begin
        rd_mux[`PPR_CTRL_FORCE_IDLE] = force_idle_reg;
      end
      `PPR_ADDR_STATUS: begin
        rd_mux[`PPR_ST_STABLE]                   = clocks_stable_reg;
        rd_mux[`PPR_ST_PWR_HI:`PPR_ST_PWR_LO]    = cur_pwr_reg;
        rd_mux[`PPR_ST_REF_LOCK]                 = ref_locked;
        rd_mux[`PPR_ST_PENDING]                  = trans_pending_reg;
      end
      `PPR_ADDR_SYMCNT: begin
        rd_mux[15:0] = sym_cnt_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // One wait-free access phase: answer is registered during setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      prdata         <= 32'h00000000;
      force_idle_reg <= `PPR_CTRL_RESET;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
      if (apb_write && (paddr == `PPR_ADDR_CTRL))
        force_idle_reg <= pwdata[`PPR_CTRL_FORCE_IDLE];
    end
  end

  //////////
  // Transmit path
  // Encoder then serializer, no extra buffering
  //////////

  wire       tx_accept;
  wire [9:0] enc_symbol;
  wire       enc_valid;
  wire       ser_sent;

  // Only full power carries data; idle requests and software hold stop it
  assign tx_accept = tx_rise & clocks_stable_reg & is_full  // [RL4]
                     & ~idle_s & ~force_idle_reg;           // [RL13]

  ppr_enc8b10b u_enc (
    .clk       (pclk),
    .rst_n     (presetn),
    .load      (tx_accept),
    .data      (byte_s),
    .is_k      (k_s),
    .force_neg (comp_s),
    .symbol    (enc_symbol),
    .sym_valid (enc_valid)
  );

  ppr_serializer u_ser (
    .clk      (pclk),
    .rst_n    (presetn),
    .sym_in   (enc_symbol),
    .sym_load (enc_valid),
    .ser_bit  (tx_serial_data),
    .ser_idle (tx_serial_idle),
    .sym_sent (ser_sent)
  );

  // Symbol counter for software visibility; wraps silently
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_cnt_reg <= 16'h0000;
    end else if (ser_sent) begin
      sym_cnt_reg <= sym_cnt_reg + 16'h0001;
    end
  end

endmodule

// File: test/ppr_checker.sv
// Purpose: Port-level checks of reset, clock and power sequencing
// Assumes: sees ppr_top ports only; one pclk domain
// Notes:   Bound to every ppr_top instance
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_checker #(
  parameter [13:0] STAB_CYCLES = `PPR_STAB_CYCLES
) (
  input logic pclk,
  input logic presetn,
  input logic rx_source_clk,
  input logic phy_done_flag,
  input logic tx_serial_idle,
  input logic tx_drive_enable,
  input logic tx_pll_enable,
  input logic rx_cdr_enable,
  input logic rx_front_power_save,
  input logic rx_fast_relock_ok
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [14:0] stab_cnt_reg;
  // Unstable cycles since reset; saturates so a hang still fails
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stab_cnt_reg <= 15'h0000;
    else if (!tx_pll_enable && stab_cnt_reg != 15'h7FFF)
      stab_cnt_reg <= stab_cnt_reg + 15'h0001;
  end
  //////////
  // Margin covers the reference lock count on top of the timer
  property p_stab_time; stab_cnt_reg <= STAB_CYCLES + 300; endproperty
  property p_done_stab; !tx_pll_enable |-> phy_done_flag; endproperty
  property p_done_fall; $rose(tx_pll_enable) |-> ##[1:12] !phy_done_flag; endproperty
  property p_ref_rate;
    $rose(rx_source_clk) && !tx_pll_enable
      |-> (rx_source_clk[*5] ##1 !rx_source_clk) or (##[1:5] tx_pll_enable);
  endproperty
  property p_run_rate;
    $rose(rx_source_clk) && $past(tx_pll_enable, 6)
      |-> rx_source_clk[*2] ##1 !rx_source_clk[*2] ##1 rx_source_clk;
  endproperty
  property p_pulse; $rose(phy_done_flag) |-> phy_done_flag[*4] ##1 !phy_done_flag; endproperty
  property p_pulse_edge; $changed(phy_done_flag) |-> $fell(rx_source_clk); endproperty
  property p_full_on; tx_drive_enable |-> rx_cdr_enable && tx_pll_enable; endproperty
  property p_unstable_off;
    !tx_pll_enable |-> !tx_drive_enable && !rx_cdr_enable && !rx_front_power_save;
  endproperty
  property p_rx_save; rx_front_power_save || rx_fast_relock_ok |-> rx_cdr_enable; endproperty
  property p_symbol; $fell(tx_serial_idle) |-> (!tx_serial_idle)[*5] ##1 (!tx_serial_idle)[*5];
  endproperty
  property p_idle_off; $fell(tx_drive_enable) |-> ##[0:25] tx_serial_idle; endproperty
  a_stab_time: assert property (p_stab_time) else $error("stabilisation too slow");
  a_done_stab: assert property (p_done_stab) else $error("done low while unstable");
  a_done_fall: assert property (p_done_fall) else $error("done stays high");
  a_ref_rate: assert property (p_ref_rate) else $error("rx clock not at ref rate");
  a_run_rate: assert property (p_run_rate) else $error("rx clock not at run rate");
  a_pulse: assert property (p_pulse) else $error("done pulse length wrong");
  a_pulse_edge: assert property (p_pulse_edge) else $error("done off rx clock fall");
  a_full_on: assert property (p_full_on) else $error("clocks off in full power");
  a_unstable_off: assert property (p_unstable_off) else $error("enable while unstable");
  a_rx_save: assert property (p_rx_save) else $error("rx saving in low power");
  a_symbol: assert property (p_symbol) else $error("symbol not ten bits");
  a_idle_off: assert property (p_idle_off) else $error("line busy after full");
  c_pulse: cover property ($rose(phy_done_flag));
  c_symbol: cover property ($fell(tx_serial_idle));
  c_rx_save: cover property (rx_front_power_save);
endmodule
bind ppr_top ppr_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.*);

// File: test/ppr_mac_model.sv
// Purpose: MAC side of the parallel transmit interface
// Assumes: free-running 80 ns transmit clock, phase unrelated to pclk
// Notes:   Inputs move on the clock fall so each rise sits mid-eye
`timescale 1ns/1ps
module ppr_mac_model (
  output logic       tx_source_clk,
  output logic [7:0] tx_byte_bus,
  output logic       tx_data_k,
  output logic [1:0] power_state_req,
  output logic       tx_elec_idle_req,
  output logic       tx_compliance_req
);
  // Same rate as the reference-rate rx clock, odd offset against pclk
  initial begin
    tx_source_clk = 1'b0;
    #13.3;
    forever #40 tx_source_clk = ~tx_source_clk;
  end
  // Safe levels out of reset: idle asserted, low power
  initial begin
    {tx_byte_bus, tx_data_k, tx_compliance_req} = 10'h000;
    power_state_req = 2'h2;
    tx_elec_idle_req = 1'b1;
  end
  // Caller waits for done before the next power change
  task put(input logic [1:0] p, input logic [7:0] b, input logic k, input logic idle);
    @(negedge tx_source_clk);
    {power_state_req, tx_byte_bus, tx_data_k, tx_elec_idle_req} <= {p, b, k, idle};
  endtask
endmodule

// File: test/ppr_top_tb.sv
// Purpose: Self-checking bench for ppr_top
// Assumes: short stabilisation timer; MAC model drives the transmit pins
// Notes:   APB results are compared against a queue of notes
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        ref_clk_in = 1'b0;
  logic        rx_elec_idle_in = 1'b0;
  wire  [31:0] prdata;
  wire  [7:0]  tx_byte_bus;
  wire  [1:0]  power_state_req;
  wire         pready, pslverr, tx_source_clk, tx_data_k, tx_elec_idle_req, tx_compliance_req;
  wire         rx_source_clk, phy_done_flag, tx_serial_data, tx_serial_idle, tx_drive_enable;
  wire         tx_pll_enable, rx_cdr_enable, rx_front_power_save, rx_fast_relock_ok;
  integer      fails = 0, checks_done = 0, seed = 32'h6179, i, n;
  logic [32:0] exp_q[$], e;
  logic [31:0] msk_q[$], r;
  logic [9:0]  s;
  logic [1:0]  st;
  logic [1:0]  seq [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
  always #4 pclk = ~pclk;
  always #5 ref_clk_in = ~ref_clk_in;
  ppr_top #(.STAB_CYCLES(14'h0028)) uut (.*);
  ppr_mac_model mac (.*);
  //////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      fails = fails + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task summarize;
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x,
           input logic [31:0] m);
    integer k;
    exp_q.push_back(x);
    msk_q.push_back(m);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k = k + 1;
      @(posedge pclk);
    end
    if (k == 50)
      fails = fails + 1;
    {psel, penable} <= 2'b00;
  endtask
  // Result side: every completed transfer answers the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      r = msk_q.pop_front();
      check(pslverr, e[32]);
      check(prdata & r, e[31:0] & r);
    end
  end
  task send(input logic [1:0] p, input logic [7:0] b, input logic k);
    mac.put(p, b, k, 1'b0);
    mac.put(p, b, k, 1'b1);
  endtask
  task get_sym;
    integer k;
    k = 0;
    while (tx_serial_idle !== 1'b0 && k < 100) begin
      @(negedge pclk);
      k = k + 1;
    end
    for (k = 9; k >= 0; k = k - 1) begin
      s[k] = tx_serial_data;
      @(negedge pclk);
    end
  endtask
  task wait_done;
    integer k;
    k = 0;
    while (phy_done_flag !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k = k + 1;
    end
    check(phy_done_flag, 32'h1);
    repeat (12) @(posedge pclk);
  endtask
  //////////
  initial begin
    #400000;
    fails = fails + 1;
    summarize;
  end
  // Main sequence: stabilise, refuse, walk power codes, send, reset again
  initial begin
    repeat (10) @(posedge pclk);
    check({30'h0, phy_done_flag, rx_source_clk}, 32'h2);
    presetn <= 1'b1;
    apb(1'b0, `PPR_ADDR_STATUS, 32'h0, 33'h0, 32'h1);
    apb(1'b1, 12'h00C, 32'h0, {1'b1, 32'h0}, 32'hFFFFFFFF);
    n = 0;
    while (tx_pll_enable !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n = n + 1;
    end
    repeat (20) @(posedge pclk);
    check(phy_done_flag, 32'h0);
    n = $random(seed);
    apb(1'b1, `PPR_ADDR_CTRL, n, 33'h0, 32'h0);
    apb(1'b0, `PPR_ADDR_CTRL, 32'h0, {32'h0, n[0]}, 32'h1);
    apb(1'b1, `PPR_ADDR_CTRL, 32'h0, 33'h0, 32'h0);
    send(2'h2, 8'hBC, 1'b1);
    repeat (30) @(posedge pclk);
    apb(1'b0, `PPR_ADDR_SYMCNT, 32'h0, 33'h0, 32'hFFFF);
    for (i = 0; i < 6; i = i + 1) begin
      mac.put(seq[i], 8'h00, 1'b0, 1'b1);
      wait_done;
      st = (seq[i] == 2'h3) ? 2'h2 : seq[i];
      apb(1'b0, `PPR_ADDR_STATUS, 32'h0, {28'h0, 2'b01, st, 1'b1}, 32'h1F);
      check({30'h0, rx_cdr_enable, tx_drive_enable}, {30'h0, st != 2'h2, st == 2'h0});
    end
    fork send(2'h0, 8'hBC, 1'b1); get_sym; join
    check(s, 32'h0FA);
    fork send(2'h0, 8'hB5, 1'b0); get_sym; join
    check(s, 32'h2AA);
    apb(1'b0, `PPR_ADDR_SYMCNT, 32'h0, 33'h2, 32'hFFFF);
    check(rx_fast_relock_ok, 32'h1);
    rx_elec_idle_in <= 1'b1;
    repeat (10) @(posedge pclk);
    check(rx_front_power_save, 32'h1);
    rx_elec_idle_in <= 1'b0;
    apb(1'b1, `PPR_ADDR_CTRL, 32'h1, 33'h0, 32'h0);
    send(2'h0, 8'hBC, 1'b1);
    repeat (30) @(posedge pclk);
    apb(1'b0, `PPR_ADDR_SYMCNT, 32'h0, 33'h2, 32'hFFFF);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check({30'h0, phy_done_flag, tx_drive_enable}, 32'h2);
    summarize;
  end
endmodule
